// File: inc/qdl_pkg.sv
// Constants and carrier types for the quad DAC parallel load control
package qdl_pkg;
   // Channel and code geometry
   localparam int QDL_NUM_CH = 4;
   localparam int QDL_CODE_W = 14;
   localparam int QDL_LOW_W = 8;
   localparam int QDL_UP_W = 6;
   localparam int QDL_SEL_W = 2;
   // APB geometry
   localparam int QDL_APB_AW = 8;
   localparam int QDL_APB_DW = 32;
   // Register byte offsets
   localparam logic [7:0] QDL_OFS_LATCH0 = 8'h00;
   localparam logic [7:0] QDL_OFS_INPUT0 = 8'h10;
   localparam logic [7:0] QDL_OFS_STATUS = 8'h20;
   localparam logic [7:0] QDL_OFS_CTRL = 8'h24;
   localparam logic [7:0] QDL_OFS_STRIDE = 8'h04;
   // Status field positions
   localparam int QDL_STAT_FROM_DAC = 0;
   localparam int QDL_STAT_CLEAR = 1;
   localparam int QDL_STAT_UPDATE = 2;
   // Control field positions
   localparam int QDL_CTRL_UPDATE = 0;
   // Values after reset
   localparam logic [13:0] QDL_CODE_RST = 14'h0000;
   localparam logic QDL_FROM_DAC_RST = 1'b0;
   localparam logic [31:0] QDL_RDATA_RST = 32'h0000_0000;

   // One host parallel-bus access, as sampled
   typedef struct packed {
      logic write;
      logic byte_shift_select;
      logic channel_select_all;
      logic [1:0] channel_sel;
      logic [13:0] data_line;
   } qdl_host_t;
endpackage

// File: verilog/qdl_channel.sv
// One DAC channel: input register and DAC latch
`timescale 1ns/10ps
module qdl_channel
   import qdl_pkg::*;
#(
   parameter int CODE_W = QDL_CODE_W,
   parameter int LOW_W = QDL_LOW_W
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_load_word,
   input wire logic i_load_upper,
   input wire logic i_update,
   input wire logic [CODE_W-1:0] i_data,
   output logic [CODE_W-1:0] o_input,
   output logic [CODE_W-1:0] o_latch
);
   localparam int UP_W = CODE_W - LOW_W;

   logic [CODE_W-1:0] input_reg; // Host-written word
   logic [CODE_W-1:0] input_next;
   logic [CODE_W-1:0] latch_reg; // Code the converter sees
   logic [CODE_W-1:0] latch_next;

   // Word write fills all bits; in byte mode top lines are grounded
   // Upper write keeps the low byte and takes the low data lines
   assign input_next = i_load_word ? i_data :
      i_load_upper ? {i_data[UP_W-1:0], input_reg[LOW_W-1:0]} :
      input_reg;

   // Latch copies the input register while update is active
   assign latch_next = i_update ? input_reg : latch_reg;

   // Storage
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         input_reg <= QDL_CODE_RST;
         latch_reg <= QDL_CODE_RST;
      end else begin
         input_reg <= input_next;
         latch_reg <= latch_next;
      end
   end

   assign o_input = input_reg;
   assign o_latch = latch_reg;
endmodule

// File: verilog/qdl_control.sv
// Quad DAC parallel load and output update control with APB view
//
// What this block does
// - Byte-shift high: whole 14-bit word in one write
// - Byte-shift high write fills the eight low bits
// - Byte-shift low write takes six upper bits
// - Update pulse copies all input registers together
// - Update held low: latches follow input registers
// - Select lines pick channel; top line selects all
// - Latch codes are straight 14-bit binary
// - Bipolar output is low reference plus scaled code
// - Update connects DAC to output until clear
// - After clear, sense ground until next update
// - Clear low at power-up: output from sense ground
// - Update low at power-up: output from DAC
// - Clear low switches all outputs to sense ground
`timescale 1ns/10ps
module qdl_control
   import qdl_pkg::*;
#(
   parameter int NUM_CH = QDL_NUM_CH,
   parameter int CODE_W = QDL_CODE_W,
   parameter int LOW_W = QDL_LOW_W
) (
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic I_CS_N,
   input wire logic I_WR_N,
   input wire logic I_BYTE_SHIFT_SELECT,
   input wire logic I_CHANNEL_SELECT_0,
   input wire logic I_CHANNEL_SELECT_1,
   input wire logic I_CHANNEL_SELECT_ALL,
   input wire logic [CODE_W-1:0] I_DATA_LINE,
   input wire logic I_LATCH_UPDATE_N,
   input wire logic I_CLEAR_TO_SENSE_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [QDL_APB_AW-1:0] I_PADDR,
   input wire logic [QDL_APB_DW-1:0] I_PWDATA,
   output logic [QDL_APB_DW-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic [NUM_CH*CODE_W-1:0] O_DAC_CODE,
   output logic O_OUT_FROM_DAC
);
   // Elaboration check: select decode serves four channels only
   if (NUM_CH != 4 || CODE_W <= LOW_W || CODE_W > 16) begin : g_bad
      $error("qdl_control: unsupported channel count or code width");
   end

   // Host bus bundle as sampled this cycle
   qdl_host_t host;
   logic wr_prev_reg; // Strobe level last cycle
   logic wr_prev_next;
   logic write_pulse; // First cycle of a selected write
   logic [NUM_CH-1:0] chan_hit; // Channels addressed by this write
   logic load_word; // Byte-shift high write
   logic load_upper; // Byte-shift low write

   assign host.write = ~I_CS_N & ~I_WR_N;
   assign host.byte_shift_select = I_BYTE_SHIFT_SELECT;
   assign host.channel_select_all = I_CHANNEL_SELECT_ALL;
   assign host.channel_sel = {I_CHANNEL_SELECT_1, I_CHANNEL_SELECT_0};
   assign host.data_line = I_DATA_LINE;

   // One load per strobe, however long the host holds it
   assign wr_prev_next = host.write;
   assign write_pulse = host.write & ~wr_prev_reg;
   assign load_word = write_pulse & host.byte_shift_select;
   assign load_upper = write_pulse & ~host.byte_shift_select;

   // Software update request, one cycle wide
   logic sw_update_reg;
   logic sw_update_next;
   logic update_active; // Strobe low or software request
   logic clear_active; // Clear input held low
   logic from_dac_reg; // Output buffer fed from DAC
   logic from_dac_next;

   assign update_active = ~I_LATCH_UPDATE_N | sw_update_reg;
   assign clear_active = ~I_CLEAR_TO_SENSE_N;

   // Clear dominates; update reconnects; otherwise hold
   // Reset stands for power-up, so the first state is sense ground
   assign from_dac_next = clear_active ? 1'b0 :
      update_active ? 1'b1 :
      from_dac_reg;

   // Channel arrays
   logic [CODE_W-1:0] input_word [NUM_CH];
   logic [CODE_W-1:0] latch_word [NUM_CH];

   // Per-channel storage and address decode
   for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
      // Top line broadcasts, else the low lines pick one
      assign chan_hit[k] = host.channel_select_all |
         (host.channel_sel == QDL_SEL_W'(k));
      qdl_channel #(
         .CODE_W(CODE_W),
         .LOW_W(LOW_W)
      ) u_ch (
         .i_clk(I_REF_CLK),
         .i_reset(I_RESET),
         .i_load_word(load_word & chan_hit[k]),
         .i_load_upper(load_upper & chan_hit[k]),
         .i_update(update_active),
         .i_data(host.data_line),
         .o_input(input_word[k]),
         .o_latch(latch_word[k])
      );
      // Straight binary code passes to the converter unchanged
      assign O_DAC_CODE[k*CODE_W +: CODE_W] = latch_word[k];
   end

   // APB decode
   logic apb_setup; // Setup phase
   logic apb_access; // Access phase, zero wait
   logic [QDL_APB_AW-1:0] reg_index; // Bank base offset, word bits masked
   logic hit_latch;
   logic hit_input;
   logic hit_status;
   logic hit_ctrl;
   logic addr_ok;
   logic [QDL_APB_DW-1:0] status_word;
   logic [QDL_APB_DW-1:0] rdata_sel;
   logic [QDL_APB_DW-1:0] rdata_next;
   logic sel_latch_ok;
   logic sel_input_ok;
   logic [1:0] bank_index;

   assign apb_setup = I_PSEL & ~I_PENABLE;
   assign apb_access = I_PSEL & I_PENABLE;
   assign reg_index = I_PADDR & ~(QDL_OFS_STRIDE * 8'h03);
   assign bank_index = I_PADDR[3:2];
   assign sel_latch_ok = I_PADDR[1:0] == 2'h0;
   assign sel_input_ok = I_PADDR[1:0] == 2'h0;
   assign hit_latch = sel_latch_ok & (reg_index == QDL_OFS_LATCH0);
   assign hit_input = sel_input_ok & (reg_index == QDL_OFS_INPUT0);
   assign hit_status = I_PADDR == QDL_OFS_STATUS;
   assign hit_ctrl = I_PADDR == QDL_OFS_CTRL;
   assign addr_ok = hit_latch | hit_input | hit_status | hit_ctrl;

   // Live state seen by software
   always_comb begin
      status_word = QDL_RDATA_RST;
      status_word[QDL_STAT_FROM_DAC] = from_dac_reg;
      status_word[QDL_STAT_CLEAR] = clear_active;
      status_word[QDL_STAT_UPDATE] = ~I_LATCH_UPDATE_N;
   end

   // Read mux; upper bits read zero
   assign rdata_sel = hit_latch ?
      QDL_APB_DW'(latch_word[bank_index]) :
      hit_input ? QDL_APB_DW'(input_word[bank_index]) :
      hit_status ? status_word : QDL_RDATA_RST;

   // Read data captured in setup, held through access
   assign rdata_next = (apb_setup & ~I_PWRITE) ? rdata_sel : O_PRDATA;

   // Control write: bit set acts as an update strobe for one cycle
   assign sw_update_next = apb_access & I_PWRITE & hit_ctrl &
      I_PWDATA[QDL_CTRL_UPDATE];

   // Zero-wait slave; unmapped addresses answer with an error
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = apb_access & ~addr_ok;

   // Control state
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         wr_prev_reg <= 1'b0;
         sw_update_reg <= 1'b0;
         from_dac_reg <= QDL_FROM_DAC_RST;
         O_PRDATA <= QDL_RDATA_RST;
      end else begin
         wr_prev_reg <= wr_prev_next;
         sw_update_reg <= sw_update_next;
         from_dac_reg <= from_dac_next;
         O_PRDATA <= rdata_next;
      end
   end

   // Buffer source select; analog level is low reference plus
   // span times code over two to the code width
   assign O_OUT_FROM_DAC = from_dac_reg;

   // Checks
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RESET);

   a_word_load_full: assert property (
      (load_word && chan_hit[0]) |=> input_word[0] == $past(I_DATA_LINE))
      else $error("word write did not land in channel 1");

   a_upper_keeps_low: assert property (
      (load_upper && chan_hit[1]) |=>
      input_word[1][LOW_W-1:0] == $past(input_word[1][LOW_W-1:0]) &&
      input_word[1][CODE_W-1:LOW_W] ==
      $past(I_DATA_LINE[CODE_W-LOW_W-1:0]))
      else $error("upper byte write corrupted channel 2");

   a_low_byte_load: assert property (
      (load_word && chan_hit[2]) |=>
      input_word[2][LOW_W-1:0] == $past(I_DATA_LINE[LOW_W-1:0]))
      else $error("low byte not stored in channel 3");

   a_update_copies: assert property (
      update_active |=> latch_word[3] == $past(input_word[3]) &&
      latch_word[0] == $past(input_word[0]))
      else $error("update did not copy input to latch");

   a_latch_holds: assert property (
      (!update_active && !sw_update_reg) |=> $stable(latch_word[2]))
      else $error("latch moved without update");

   a_clear_forces: assert property (
      clear_active |=> !O_OUT_FROM_DAC)
      else $error("clear did not force sense ground");

   a_stay_cleared: assert property (
      (!O_OUT_FROM_DAC && I_LATCH_UPDATE_N && !sw_update_reg)
      |=> !O_OUT_FROM_DAC)
      else $error("output reconnected without update");

   a_update_connect: assert property (
      (update_active && !clear_active) |=> O_OUT_FROM_DAC ##1
      (O_OUT_FROM_DAC || $past(clear_active)))
      else $error("update failed to connect DAC");

   a_write_once: assert property (
      write_pulse |=> !write_pulse)
      else $error("held strobe loaded twice");

   a_broadcast: assert property (
      (load_word && host.channel_select_all) |=>
      input_word[0] == input_word[3] && input_word[1] == input_word[2])
      else $error("broadcast write missed a channel");

   a_reset_sense: assert property (
      @(posedge I_REF_CLK) disable iff (1'b0)
      I_RESET |=> !O_OUT_FROM_DAC)
      else $error("output not at sense ground after power-up");
endmodule

// File: tb/qdl_host_model.sv
// Host parallel-bus model that loads the DAC input registers
`timescale 1ns/10ps
module qdl_host_model
   import qdl_pkg::*;
(
   input wire logic i_clk,
   output qdl_host_t o_bus
);
   logic ground_up = 1'b0; // Upper lines strapped low in byte mode
   // Idle bus: strobe high, data meaningless
   initial begin
      o_bus = '{1'b0, 1'b1, 1'b0, 2'h0, 14'h2AAA};
   end
   // Strobe low one cycle; released data is inverted, not held
   task automatic put(input logic bss, input logic all,
         input logic [1:0] ch, input logic [13:0] d);
      @(posedge i_clk);
      o_bus <= '{1'b1, bss, all, ch, d};
      @(posedge i_clk);
      o_bus.write <= 1'b0;
      o_bus.data_line <= {ground_up ? 6'h00 : ~d[13:8], ~d[7:0]};
   endtask
   // Low byte first, then six upper bits on the low lines
   task automatic put_bytes(input logic [1:0] ch, input logic [13:0] d);
      ground_up = 1'b1;
      put(1'b1, 1'b0, ch, {6'h00, d[7:0]});
      put(1'b0, 1'b0, ch, {8'h00, d[13:8]});
      ground_up = 1'b0;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the quad DAC parallel load control
`timescale 1ns/10ps
module testbench;
   import qdl_pkg::*;
   logic clk = 1'b0; // 25 MHz reference
   logic rst = 1'b1;
   logic upd_n = 1'b1; // Update strobe, active low
   logic clr_n = 1'b0; // Clear held low through power-up
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [55:0] code;
   logic from_dac;
   qdl_host_t hb;
   logic [13:0] inreg [4] = '{default: 14'h0000}; // Expected inputs
   logic [13:0] lt [4] = '{default: 14'h0000}; // Expected latches
   logic [32:0] expq [$]; // Expected {error, read data}
   logic [32:0] me;
   logic [31:0] xs = 32'h0000_EF0A;
   logic [13:0] d;
   int failures = 0;
   int checked = 0;
   int cycles = 0;

   always #20 clk = ~clk;

   qdl_control i_qdl_control (.I_REF_CLK(clk), .I_RESET(rst),
      .I_CS_N(~hb.write), .I_WR_N(~hb.write),
      .I_BYTE_SHIFT_SELECT(hb.byte_shift_select),
      .I_CHANNEL_SELECT_0(hb.channel_sel[0]),
      .I_CHANNEL_SELECT_1(hb.channel_sel[1]),
      .I_CHANNEL_SELECT_ALL(hb.channel_select_all),
      .I_DATA_LINE(hb.data_line), .I_LATCH_UPDATE_N(upd_n),
      .I_CLEAR_TO_SENSE_N(clr_n), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .O_DAC_CODE(code), .O_OUT_FROM_DAC(from_dac));
   qdl_host_model i_qdl_host_model (.i_clk(clk), .o_bus(hb));

   // Fixed-seed xorshift source
   function automatic logic [31:0] rnd();
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      return xs;
   endfunction
   task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // APB master: request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, input logic [32:0] e);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      if (!w) expq.push_back(e);
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk_in();
      for (int k = 0; k < 4; k++)
         apb(1'b0, QDL_OFS_INPUT0 + 8'(4 * k), 32'h0, {19'h0, inreg[k]});
   endtask
   task automatic chk_lat();
      cmp(code, {lt[3], lt[2], lt[1], lt[0]});
      for (int k = 0; k < 4; k++)
         apb(1'b0, QDL_OFS_LATCH0 + 8'(4 * k), 32'h0, {19'h0, lt[k]});
   endtask
   // One-cycle update strobe; latches take all inputs together
   task automatic pulse();
      @(posedge clk);
      upd_n <= 1'b0;
      @(posedge clk);
      upd_n <= 1'b1;
      lt = inreg;
      @(posedge clk);
   endtask

   // Read monitor: oldest note against the answer at the access edge
   always @(posedge clk) begin
      if (psel && pen && pready === 1'b1 && !pwr) begin
         me = expq.pop_front();
         cmp(pslverr, me[32]);
         if (!me[32]) cmp(prdata, me[31:0]);
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      tick(3);
      rst <= 1'b0;
      tick(3);
      cmp(from_dac, 1'b0);
      cmp(code, 56'h0);
      clr_n <= 1'b1;
      $display("test power-up clear done");
      for (int k = 0; k < 4; k++) begin
         d = 14'(rnd());
         i_qdl_host_model.put(1'b1, 1'b0, 2'(k), d);
         inreg[k] = d;
      end
      chk_in();
      cmp(code, 56'h0);
      pulse();
      chk_lat();
      cmp(from_dac, 1'b1);
      apb(1'b0, QDL_OFS_STATUS, 32'h0, {1'b0, 32'h1});
      $display("test word load done");
      d = 14'(rnd());
      i_qdl_host_model.put_bytes(2'h2, d);
      inreg[2] = d;
      chk_in();
      chk_lat();
      pulse();
      chk_lat();
      $display("test byte load done");
      d = 14'(rnd());
      i_qdl_host_model.put(1'b1, 1'b1, d[1:0], 14'h3FFF);
      inreg = '{default: 14'h3FFF};
      chk_in();
      pulse();
      chk_lat();
      $display("test all select done");
      // Clear and update low together: clear must win
      @(posedge clk);
      clr_n <= 1'b0;
      upd_n <= 1'b0;
      @(posedge clk);
      clr_n <= 1'b1;
      upd_n <= 1'b1;
      @(posedge clk);
      cmp(from_dac, 1'b0);
      tick(3);
      cmp(from_dac, 1'b0);
      chk_lat();
      pulse();
      cmp(from_dac, 1'b1);
      $display("test clear done");
      @(posedge clk);
      upd_n <= 1'b0;
      d = 14'(rnd());
      i_qdl_host_model.put(1'b1, 1'b0, 2'h1, d);
      inreg[1] = d;
      lt = inreg;
      tick(2);
      cmp(code[27:14], d);
      upd_n <= 1'b1;
      $display("test follow mode done");
      i_qdl_host_model.put(1'b1, 1'b0, 2'h0, 14'h2000);
      inreg[0] = 14'h2000;
      apb(1'b1, QDL_OFS_CTRL, 32'h1, 33'h0);
      tick(2);
      lt = inreg;
      chk_lat();
      apb(1'b1, QDL_OFS_INPUT0, 32'h155, 33'h0);
      chk_in();
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      $display("test register view done");
      @(posedge clk);
      rst <= 1'b1;
      upd_n <= 1'b0;
      tick(3);
      rst <= 1'b0;
      tick(3);
      cmp(from_dac, 1'b1);
      cmp(code, 56'h0);
      $display("test power-up update done");
      tick(2);
      wrap_up();
   end
endmodule
